//--- design/prt_defines.svh
// Register offsets, field positions, reset values and codes for the position range block
`ifndef PRT_DEFINES_SVH
`define PRT_DEFINES_SVH
// Register byte offsets
`define PRT_OFF_CTRL 8'h00
`define PRT_OFF_FWD_LIMIT 8'h04
`define PRT_OFF_REV_LIMIT 8'h08
`define PRT_OFF_TEACH_SEL 8'h0c
`define PRT_OFF_STATUS 8'h10
`define PRT_OFF_POSITION 8'h14
`define PRT_OFF_STORE 8'h18
`define PRT_OFF_TERM_LO 8'h1c
`define PRT_OFF_TERM_HI 8'h20
`define PRT_OFF_SLOT_BASE 8'h40
`define PRT_OFF_SLOT_LAST 8'h5c
// Control pulse setting codes that enable teaching
`define PRT_MODE_ABS 8'h02
`define PRT_MODE_ABS_HIRES 8'h03
// Terminal function code for teaching
`define PRT_FUNC_TEACH 8'h2d
// Status field positions
`define PRT_ST_TRIP 0
`define PRT_ST_FWD_FAULT 1
`define PRT_ST_REV_FAULT 2
`define PRT_ST_TEACH_ACTIVE 3
`define PRT_ST_TEACH_EN 4
// Store register: bit that requests a store
`define PRT_STORE_BIT 0
// Reset values
`define PRT_RST_MODE 8'h00
`define PRT_RST_LIMIT 32'h0000_0000
`define PRT_RST_TEACH_SEL 3'h0
`define PRT_RST_TERM_FUNC 64'h0000_0000_0000_0000
`endif

//--- design/prt_pkg.sv
// Types shared by the position range and teaching block
package prt_pkg;
  // Bus access phases, one-hot
  typedef enum logic [2:0] {
    PRT_IDLE = 3'b001,
    PRT_FETCH = 3'b010,
    PRT_ACK = 3'b100
  } prt_phase_e;
  // Position count type
  typedef logic signed [31:0] prt_pos_t;
endpackage

//--- design/prt_slot_mem.sv
// Eight-word store for the multistage position slots
`timescale 1ns/100ps
module prt_slot_mem (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Write port
  input wire logic we,
  input wire logic [2:0] waddr,
  input wire logic [31:0] wdata,
  // Read port, data registered
  input wire logic [2:0] raddr,
  output logic [31:0] rdata
);
  // Slot storage, no reset as for any memory
  logic [31:0] mem [0:7];

  // Write side
  always_ff @(posedge clock) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
  end

  // Registered read, cleared by reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      rdata <= 32'h0000_0000;
    end else begin
      rdata <= mem[raddr];
    end
  end
endmodule

//--- design/prt_range_teach.sv
// Position range supervision, slot clamping and teaching with an Avalon-MM slave
//
// Function
// - Trip and free-run when position leaves range
// - Clamp every slot value to the range
// - Teaching only in absolute position modes 02/03
// - Teaching needs a terminal assigned function 45
// - Teach run latches speed and ramp at acceptance
// - Store key copies position into selected slot
// - Selector 00..07 maps straight to slots 0..7
// - Selector not retained, resets to 00
// - Position counts even while drive idle
// - Zero-return completion clears the position count
//
// The register addresses and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/100ps
`include "prt_defines.svh"
module prt_range_teach (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Avalon-MM slave
  input wire logic [7:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  output logic [31:0] readdata,
  output logic waitrequest,
  // Intelligent input terminals 1..8
  input wire logic [7:0] terminal_in,
  // Drive core: position movement and run command
  input wire logic pos_step,
  input wire logic pos_dir_rev,
  input wire logic zero_return_done,
  input wire logic run_cmd,
  input wire logic [15:0] speed_setting,
  input wire logic [15:0] accel_setting,
  // Drive core outputs
  output logic trip_reg,
  output logic free_run_reg,
  output logic fwd_fault_reg,
  output logic rev_fault_reg,
  output logic teach_run_reg,
  output logic [15:0] teach_speed_reg,
  output logic [15:0] teach_accel_reg
);
  // Software settings
  logic [7:0] control_pulse_setting_reg;
  logic [31:0] forward_range_limit_reg;
  logic [31:0] reverse_range_limit_reg;
  logic [2:0] teach_slot_selector_reg;
  logic [63:0] term_func_reg;
  // Live position count
  prt_pkg::prt_pos_t position_reg;
  // Bus phase and latched request
  prt_pkg::prt_phase_e phase_reg;
  logic [7:0] addr_reg;
  logic wr_reg;
  logic [31:0] wdata_reg;
  // Teach input decode and run edge
  logic teach_en;
  logic teach_input;
  logic run_prev_reg;
  // Slot memory ports
  logic mem_we;
  logic [2:0] mem_waddr;
  logic [31:0] mem_wdata;
  logic [31:0] mem_rdata;
  logic [2:0] mem_raddr;
  // Write accepted in this cycle
  logic accept;
  logic is_slot;

  // Keep a value inside [-reverse, +forward]
  function automatic logic [31:0] clamp_pos(input logic [31:0] v, input logic [31:0] fwd,
                                            input logic [31:0] rev);
    logic signed [31:0] sv;
    logic signed [31:0] lo;
    sv = $signed(v);
    lo = -$signed(rev);
    if (sv > $signed(fwd)) begin
      clamp_pos = fwd;
    end else if (sv < lo) begin
      clamp_pos = lo;
    end else begin
      clamp_pos = v;
    end
  endfunction

  // Slot window decode
  function automatic logic slot_hit(input logic [7:0] a);
    slot_hit = (a >= `PRT_OFF_SLOT_BASE) && (a <= `PRT_OFF_SLOT_LAST) && (a[1:0] == 2'h0);
  endfunction

  // Teaching enable and terminal pick
  always_comb begin
    teach_input = 1'b0;
    teach_en = 1'b0;
    for (int i = 0; i < 8; i++) begin
      if (term_func_reg[i*8 +: 8] == `PRT_FUNC_TEACH) begin
        teach_en = 1'b1;
        teach_input = teach_input | terminal_in[i];
      end
    end
    if ((control_pulse_setting_reg != `PRT_MODE_ABS) &&
        (control_pulse_setting_reg != `PRT_MODE_ABS_HIRES)) begin
      teach_en = 1'b0;
      teach_input = 1'b0;
    end
  end

  // Write accepted at the edge where waitrequest is low
  assign accept = (phase_reg == prt_pkg::PRT_ACK) && wr_reg;
  assign is_slot = slot_hit(addr_reg);
  // Slot read address follows the bus while idle, so the word is ready at the fetch edge
  assign mem_raddr = (phase_reg == prt_pkg::PRT_IDLE) ? address[4:2] : addr_reg[4:2];

  // Bus phases: latch, fetch, answer with waitrequest low
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      phase_reg <= prt_pkg::PRT_IDLE;
      waitrequest <= 1'b1;
      addr_reg <= 8'h00;
      wr_reg <= 1'b0;
      wdata_reg <= 32'h0000_0000;
    end else begin
      unique case (phase_reg)
        prt_pkg::PRT_IDLE: begin
          // Capture a new request
          if (read || write) begin
            addr_reg <= address;
            wr_reg <= write;
            wdata_reg <= writedata;
            phase_reg <= prt_pkg::PRT_FETCH;
          end
        end
        prt_pkg::PRT_FETCH: begin
          // Slot read data now ready, answer next
          waitrequest <= 1'b0;
          phase_reg <= prt_pkg::PRT_ACK;
        end
        prt_pkg::PRT_ACK: begin
          // Master samples here, release
          waitrequest <= 1'b1;
          phase_reg <= prt_pkg::PRT_IDLE;
        end
      endcase
    end
  end

  // Read data mux, registered for the answer cycle
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      readdata <= 32'h0000_0000;
    end else if (phase_reg == prt_pkg::PRT_FETCH) begin
      if (is_slot) begin
        readdata <= mem_rdata;
      end else begin
        unique case (addr_reg)
          `PRT_OFF_CTRL: readdata <= {24'h00_0000, control_pulse_setting_reg};
          `PRT_OFF_FWD_LIMIT: readdata <= forward_range_limit_reg;
          `PRT_OFF_REV_LIMIT: readdata <= reverse_range_limit_reg;
          `PRT_OFF_TEACH_SEL: readdata <= {29'h0000_0000, teach_slot_selector_reg};
          `PRT_OFF_STATUS: readdata <= {27'h000_0000, teach_en, teach_input,
                                        rev_fault_reg, fwd_fault_reg, trip_reg};
          `PRT_OFF_POSITION: readdata <= position_reg;
          `PRT_OFF_TERM_LO: readdata <= term_func_reg[31:0];
          `PRT_OFF_TERM_HI: readdata <= term_func_reg[63:32];
          // Unmapped and store register read as zero
          default: readdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Setting registers written by software
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      control_pulse_setting_reg <= `PRT_RST_MODE;
      forward_range_limit_reg <= `PRT_RST_LIMIT;
      reverse_range_limit_reg <= `PRT_RST_LIMIT;
      term_func_reg <= `PRT_RST_TERM_FUNC;
    end else if (accept) begin
      unique case (addr_reg)
        `PRT_OFF_CTRL: control_pulse_setting_reg <= wdata_reg[7:0];
        `PRT_OFF_FWD_LIMIT: forward_range_limit_reg <= wdata_reg;
        `PRT_OFF_REV_LIMIT: reverse_range_limit_reg <= wdata_reg;
        `PRT_OFF_TERM_LO: term_func_reg[31:0] <= wdata_reg;
        `PRT_OFF_TERM_HI: term_func_reg[63:32] <= wdata_reg;
        // Other offsets leave settings alone
        default: ;
      endcase
    end
  end

  // Volatile teach slot selector
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      teach_slot_selector_reg <= `PRT_RST_TEACH_SEL;
    end else if (accept && (addr_reg == `PRT_OFF_TEACH_SEL)) begin
      teach_slot_selector_reg <= wdata_reg[2:0];
    end
  end

  // Slot writes: bus write or store key, both clamped
  always_comb begin
    mem_we = 1'b0;
    mem_waddr = addr_reg[4:2];
    mem_wdata = clamp_pos(wdata_reg, forward_range_limit_reg, reverse_range_limit_reg);
    if (accept && is_slot) begin
      mem_we = 1'b1;
    end else if (accept && (addr_reg == `PRT_OFF_STORE) &&
                 wdata_reg[`PRT_STORE_BIT] && teach_en) begin
      mem_we = 1'b1;
      mem_waddr = teach_slot_selector_reg;
      mem_wdata = clamp_pos(position_reg, forward_range_limit_reg,
                            reverse_range_limit_reg);
    end
  end

  // Slot memory
  prt_slot_mem u_slots (
    .clock(clock),
    .rst_n(rst_n),
    .we(mem_we),
    .waddr(mem_waddr),
    .wdata(mem_wdata),
    .raddr(mem_raddr),
    .rdata(mem_rdata)
  );

  // Position counter, runs whether or not the drive runs
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      position_reg <= 32'sh0000_0000;
    end else if (zero_return_done) begin
      position_reg <= 32'sh0000_0000;
    end else if (pos_step) begin
      position_reg <= pos_dir_rev ? position_reg - 32'sh1 : position_reg + 32'sh1;
    end
  end

  // Range check every cycle; faults stick until reset
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      fwd_fault_reg <= 1'b0;
      rev_fault_reg <= 1'b0;
      trip_reg <= 1'b0;
      free_run_reg <= 1'b0;
    end else begin
      if (position_reg > $signed(forward_range_limit_reg)) begin
        fwd_fault_reg <= 1'b1;
        trip_reg <= 1'b1;
        free_run_reg <= 1'b1;
      end
      if (position_reg < -$signed(reverse_range_limit_reg)) begin
        rev_fault_reg <= 1'b1;
        trip_reg <= 1'b1;
        free_run_reg <= 1'b1;
      end
    end
  end

  // Teach run: latch speed and ramp on run acceptance
  always_ff @(posedge clock) begin
    if (!rst_n) begin
      run_prev_reg <= 1'b0;
      teach_run_reg <= 1'b0;
      teach_speed_reg <= 16'h0000;
      teach_accel_reg <= 16'h0000;
    end else begin
      run_prev_reg <= run_cmd;
      if (run_cmd && !run_prev_reg && teach_input && !trip_reg) begin
        teach_run_reg <= 1'b1;
        teach_speed_reg <= speed_setting;
        teach_accel_reg <= accel_setting;
      end else if (!run_cmd || trip_reg) begin
        teach_run_reg <= 1'b0;
      end
    end
  end
endmodule

//--- verification/prt_range_teach_assertions.sv
// Port checks for the position range and teaching block
`timescale 1ns/100ps
module prt_range_teach_checker (
  // Clock and reset
  input wire logic clock,
  input wire logic rst_n,
  // Bus handshake
  input wire logic read,
  input wire logic write,
  input wire logic waitrequest,
  // Drive core
  input wire logic run_cmd,
  input wire logic [15:0] speed_setting,
  input wire logic [15:0] accel_setting,
  input wire logic trip_reg,
  input wire logic free_run_reg,
  input wire logic fwd_fault_reg,
  input wire logic rev_fault_reg,
  input wire logic teach_run_reg,
  input wire logic [15:0] teach_speed_reg,
  input wire logic [15:0] teach_accel_reg
);
  // Single clock domain
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Two busy cycles before the answer
  sequence s_busy2;
    waitrequest ##1 waitrequest;
  endsequence
  a_bus_latency: assert property ($rose(read || write) |-> s_busy2 ##1 !waitrequest)
    else $error("bus answer latency wrong");
  a_ack_single: assert property (!waitrequest |=> waitrequest)
    else $error("answer longer than one cycle");
  a_no_idle_ack: assert property (!(read || write) |-> waitrequest)
    else $error("answer without request");
  a_free_run: assert property (free_run_reg == trip_reg)
    else $error("free run differs from trip");
  a_trip_cause: assert property (trip_reg |-> (fwd_fault_reg || rev_fault_reg))
    else $error("trip without fault cause");
  a_faults_sticky: assert property (!$fell(trip_reg) && !$fell(fwd_fault_reg)
    && !$fell(rev_fault_reg))
    else $error("fault cleared without reset");
  a_teach_latch: assert property ($rose(teach_run_reg) |->
    teach_speed_reg == $past(speed_setting) && teach_accel_reg == $past(accel_setting))
    else $error("teach settings not latched");
  a_teach_hold: assert property (teach_run_reg && $past(teach_run_reg) |->
    $stable(teach_speed_reg) && $stable(teach_accel_reg))
    else $error("teach settings moved during run");
  a_teach_drop: assert property ((!run_cmd || trip_reg) |=> !teach_run_reg)
    else $error("teach run not dropped");
endmodule

//--- verification/prt_partner.sv
// Keypad, terminal and position counter model on the drive side
`timescale 1ns/100ps
module prt_partner (
  // Clock
  input wire logic clock,
  // Position counter
  output logic pos_step,
  output logic pos_dir_rev,
  output logic zero_return_done,
  // Terminals and run command
  output logic [7:0] terminal_in,
  output logic run_cmd,
  output logic [15:0] speed_setting,
  output logic [15:0] accel_setting
);
  // Quiet levels at time zero
  initial begin
    pos_step = 1'b0;
    pos_dir_rev = 1'b0;
    zero_return_done = 1'b0;
    terminal_in = 8'h00;
    run_cmd = 1'b0;
    speed_setting = 16'h0000;
    accel_setting = 16'h0000;
  end
  // External equipment moves the workpiece n counts
  task automatic move(input int n, input logic rev);
    repeat (n) begin
      @(posedge clock);
      pos_step <= 1'b1;
      pos_dir_rev <= rev;
      @(posedge clock);
      pos_step <= 1'b0;
    end
  endtask
  // One-cycle zero-return completion pulse
  task automatic zero();
    @(posedge clock);
    zero_return_done <= 1'b1;
    @(posedge clock);
    zero_return_done <= 1'b0;
  endtask
endmodule

//--- verification/tb_position_range_and_teaching.sv
// Self-checking bench for the position range and teaching block
`timescale 1ns/100ps
`include "prt_defines.svh"
module tb_position_range_and_teaching;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic [7:0] address = 8'h00;
  logic read = 1'b0;
  logic write = 1'b0;
  logic [31:0] writedata = 32'h0;
  logic [31:0] readdata, rd;
  logic waitrequest, pos_step, pos_dir_rev, zero_return_done, run_cmd;
  logic [7:0] terminal_in;
  logic [15:0] speed_setting, accel_setting, teach_speed_reg, teach_accel_reg;
  logic trip_reg, free_run_reg, fwd_fault_reg, rev_fault_reg, teach_run_reg;
  int mismatches = 0;
  int cmp_count = 0;
  // Clock, 40 ns period
  always #20 clock = ~clock;
  prt_range_teach i_dut (.clock, .rst_n, .address, .read, .write, .writedata, .readdata,
    .waitrequest, .terminal_in, .pos_step, .pos_dir_rev, .zero_return_done, .run_cmd,
    .speed_setting, .accel_setting, .trip_reg, .free_run_reg, .fwd_fault_reg,
    .rev_fault_reg, .teach_run_reg, .teach_speed_reg, .teach_accel_reg);
  prt_partner i_part (.clock, .pos_step, .pos_dir_rev, .zero_return_done, .terminal_in,
    .run_cmd, .speed_setting, .accel_setting);
  // Compare and count
  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    cmp_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  // One bus access, held until waitrequest is seen low
  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    address <= a;
    writedata <= d;
    write <= wr;
    read <= !wr;
    // Only the watchdog ends a wait that never answers
    do begin
      @(posedge clock);
    end while (waitrequest !== 1'b0);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
  endtask
  // Synchronous reset for 2 cycles
  task automatic do_reset();
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
  endtask
  // Teach every slot through the selector
  task automatic t_teach();
    bus(0, `PRT_OFF_TEACH_SEL, 0);
    chk("selector", 32'h0, rd);
    bus(1, `PRT_OFF_FWD_LIMIT, 32'h3);
    bus(1, `PRT_OFF_REV_LIMIT, 32'h2);
    bus(1, `PRT_OFF_CTRL, {24'h0, `PRT_MODE_ABS});
    bus(1, `PRT_OFF_TERM_HI, {`PRT_FUNC_TEACH, 24'h0});
    i_part.terminal_in <= 8'h80;
    bus(0, `PRT_OFF_STATUS, 0);
    chk("status", 32'h18, rd);
    for (int s = 0; s < 8; s++) begin
      bus(1, `PRT_OFF_TEACH_SEL, 32'(s));
      i_part.move(1, s > 2);
      bus(1, `PRT_OFF_STORE, 32'h1);
    end
    for (int s = 0; s < 8; s++) begin
      bus(0, `PRT_OFF_SLOT_BASE + 8'(4 * s), 0);
      chk("slot", 32'(s < 3 ? s + 1 : 5 - s), rd);
    end
    bus(0, `PRT_OFF_POSITION, 0);
    chk("position", 32'hffff_fffe, rd);
    $display("test teach done");
  endtask
  // Slot clamping and store gating by mode
  task automatic t_clamp();
    bus(1, `PRT_OFF_SLOT_BASE, 32'h64);
    bus(0, `PRT_OFF_SLOT_BASE, 0);
    chk("clamp fwd", 32'h3, rd);
    bus(1, `PRT_OFF_SLOT_BASE + 8'h04, 32'hffff_ff9c);
    bus(0, `PRT_OFF_SLOT_BASE + 8'h04, 0);
    chk("clamp rev", 32'hffff_fffe, rd);
    bus(1, `PRT_OFF_TEACH_SEL, 0);
    bus(1, `PRT_OFF_CTRL, 32'h1);
    bus(1, `PRT_OFF_STORE, 32'h1);
    bus(0, `PRT_OFF_SLOT_BASE, 0);
    chk("store refused", 32'h3, rd);
    bus(1, `PRT_OFF_CTRL, {24'h0, `PRT_MODE_ABS_HIRES});
    bus(1, `PRT_OFF_STORE, 32'h1);
    bus(0, `PRT_OFF_SLOT_BASE, 0);
    chk("store hires", 32'hffff_fffe, rd);
    bus(1, `PRT_OFF_TERM_LO, {24'h0, `PRT_FUNC_TEACH});
    bus(1, `PRT_OFF_TERM_HI, 32'h0);
    bus(0, `PRT_OFF_TERM_LO, 0);
    chk("term lo", {24'h0, `PRT_FUNC_TEACH}, rd);
    bus(0, `PRT_OFF_STATUS, 0);
    chk("status lo", 32'h10, rd);
    i_part.terminal_in <= 8'h01;
    $display("test clamp done");
  endtask
  // Teach run latches settings at acceptance
  task automatic t_run();
    i_part.speed_setting <= 16'h0123;
    i_part.accel_setting <= 16'h0045;
    @(posedge clock);
    i_part.run_cmd <= 1'b1;
    repeat (3) @(posedge clock);
    i_part.speed_setting <= 16'h0777;
    repeat (2) @(posedge clock);
    chk("teach run", 32'h1, {31'h0, teach_run_reg});
    chk("teach set", 32'h0123_0045, {teach_speed_reg, teach_accel_reg});
    i_part.run_cmd <= 1'b0;
    repeat (3) @(posedge clock);
    chk("teach stop", 32'h0, {31'h0, teach_run_reg});
    i_part.terminal_in <= 8'h00;
    i_part.run_cmd <= 1'b1;
    repeat (3) @(posedge clock);
    chk("teach refused", 32'h0, {31'h0, teach_run_reg});
    i_part.run_cmd <= 1'b0;
    $display("test run done");
  endtask
  // Zero return, overrun trips, trip held until reset
  task automatic t_trip();
    i_part.zero();
    bus(0, `PRT_OFF_POSITION, 0);
    chk("zero return", 32'h0, rd);
    i_part.move(4, 1'b0);
    repeat (3) @(posedge clock);
    chk("fwd trip", 32'h7, {28'h0, rev_fault_reg, trip_reg, free_run_reg, fwd_fault_reg});
    i_part.move(4, 1'b1);
    repeat (3) @(posedge clock);
    chk("trip held", 32'h1, {31'h0, trip_reg});
    bus(1, `PRT_OFF_TEACH_SEL, 32'h5);
    do_reset();
    bus(0, `PRT_OFF_TEACH_SEL, 0);
    chk("selector cleared", 32'h0, rd);
    i_part.move(1, 1'b1);
    repeat (3) @(posedge clock);
    chk("rev trip", 32'he, {28'h0, rev_fault_reg, trip_reg, free_run_reg, fwd_fault_reg});
    $display("test trip done");
  endtask
  // Verdict and end of run
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  // Main sequence
  initial begin
    do_reset();
    t_teach();
    t_clamp();
    t_run();
    t_trip();
    results();
  end
  // Watchdog
  initial begin
    #(40 * 4000);
    mismatches++;
    results();
  end
endmodule
bind prt_range_teach prt_range_teach_checker i_chk (.clock, .rst_n, .read, .write,
  .waitrequest, .run_cmd, .speed_setting, .accel_setting, .trip_reg, .free_run_reg,
  .fwd_fault_reg, .rev_fault_reg, .teach_run_reg, .teach_speed_reg, .teach_accel_reg);
